// ---- gafm_pkg.sv ----
// gafm_pkg: constants for the general purpose pin multiplexer
// assumes: one 250 MHz clock, pins indexed 0..11 with 8..10 unbonded
package gafm_pkg;
  localparam int PIN_W = 12;
  localparam logic [11:0] PIN_PRESENT = 12'h8FF;
  localparam logic [11:0] ALT_CAPABLE = 12'h097;
  localparam int PIN_DS_A_RST = 0;
  localparam int PIN_DS_B_RST = 1;
  localparam int PIN_EXP_IRQ0 = 2;
  localparam int PIN_EXP_IRQ2 = 4;
  localparam int PIN_GEN_EVENT = 7;
  localparam logic [11:0] RST_DIR = 12'h000;
  localparam logic [11:0] RST_ALT = 12'h000;
  localparam logic [11:0] RST_OUT = 12'h000;
  localparam logic [11:0] RST_IN = 12'h000;
  typedef enum logic [1:0] {
    GAFM_HP_IDLE,
    GAFM_HP_REQ,
    GAFM_HP_WAIT
  } gafm_hp_state_t;
endpackage : gafm_pkg

// ---- gafm_mux.sv ----
// gafm_mux: general purpose pin multiplexer with alternate functions
// assumes: synchronous pin inputs, hot-plug reads done by an external master engine
//
// Contract
// RULE_01: pins 0-7 and 11 offer software bit I/O instead of alternate function.
// RULE_02: names ending _n are asserted low; all others asserted high.
// RULE_03: pin 0 alternate drives active-low reset of downstream port A.
// RULE_04: pin 1 alternate drives active-low reset of downstream port B.
// RULE_05: pin 2 alternate receives active-low interrupt from expander 0.
// RULE_06: pin 4 alternate receives active-low interrupt from expander 2.
// RULE_07: pin 7 alternate drives active-low general event output.
// RULE_08: each pin independently set as input or output by software.
// RULE_09: alternate select comes from software, slave bus or eeprom load.
// RULE_10: expander interrupt triggers a read of all hot-plug inputs.
// RULE_11: pins 3,5,6,11 have no alternate; select ignored there.
`timescale 1ns/100ps
module gafm_mux (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic [11:0] I_SW_DIR,
  input wire logic [11:0] I_SW_OUT,
  input wire logic [11:0] I_SW_ALT,
  input wire logic I_SW_ALT_WE,
  input wire logic [11:0] I_SMB_ALT,
  input wire logic I_SMB_ALT_WE,
  input wire logic [11:0] I_EE_ALT,
  input wire logic I_EE_ALT_WE,
  input wire logic I_DS_A_RESET,
  input wire logic I_DS_B_RESET,
  input wire logic I_GENERAL_EVENT,
  input wire logic I_HP_READ_DONE,
  input wire logic [11:0] I_PIN_IN,
  output logic [11:0] O_PIN_OUT,
  output logic [11:0] O_PIN_OE,
  output logic [11:0] O_GPIO_IN,
  output logic [11:0] O_ALT_SEL,
  output logic O_EXPANDER_IRQ0,
  output logic O_EXPANDER_IRQ2,
  output logic O_HP_READ_REQ
);
  logic [11:0] alt_r;
  logic [11:0] alt_nxt;
  logic [11:0] alt_eff;
  logic [11:0] alt_drv;
  logic [11:0] alt_oe;
  logic [11:0] gp_oe;
  logic [11:0] pin_out_nxt;
  logic [11:0] pin_oe_nxt;
  logic irq_any;
  logic irq_prev_r;
  logic irq_edge;
  gafm_pkg::gafm_hp_state_t hp_r;
  gafm_pkg::gafm_hp_state_t hp_nxt;

  logic irq0_now;
  logic irq2_now;
  logic [11:0] gpio_in_nxt;

  // an expander line counts only while its pin is switched over and held low
  function automatic logic irq_seen(input logic sel, input logic level_n);
    irq_seen = sel & ~level_n; // RULE_02
  endfunction : irq_seen

  // eeprom load wins over the slave bus, which wins over software
  assign alt_nxt = I_EE_ALT_WE ? I_EE_ALT :
                   I_SMB_ALT_WE ? I_SMB_ALT :
                   I_SW_ALT_WE ? I_SW_ALT : alt_r; // RULE_09
  assign alt_eff = alt_r & gafm_pkg::ALT_CAPABLE; // RULE_11

  a_alt_load: assert property ( // RULE_09
    @(posedge I_MCLK) disable iff (!I_RST_N)
    I_EE_ALT_WE |=> alt_r == $past(I_EE_ALT)
  ) else $error("eeprom alternate load lost");

  a_alt_slave: assert property ( // RULE_09
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (I_SMB_ALT_WE && !I_EE_ALT_WE) |=> alt_r == $past(I_SMB_ALT)
  ) else $error("slave bus alternate load lost");

  a_alt_soft: assert property ( // RULE_09
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (I_SW_ALT_WE && !I_SMB_ALT_WE && !I_EE_ALT_WE) |=> alt_r == $past(I_SW_ALT)
  ) else $error("software alternate load lost");

  a_alt_hold: assert property ( // RULE_09
    @(posedge I_MCLK) disable iff (!I_RST_N)
    !(I_SW_ALT_WE || I_SMB_ALT_WE || I_EE_ALT_WE) |=> $stable(alt_r)
  ) else $error("alternate select changed without a write");

  a_no_alt_pins: assert property ( // RULE_11
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (O_ALT_SEL & ~gafm_pkg::ALT_CAPABLE) == 12'h000
  ) else $error("alternate on pin without one");

  always_comb begin
    alt_drv = 12'h000;
    alt_oe = 12'h000;
    alt_drv[gafm_pkg::PIN_DS_A_RST] = ~I_DS_A_RESET; // RULE_03
    alt_oe[gafm_pkg::PIN_DS_A_RST] = 1'h1; // RULE_03
    alt_drv[gafm_pkg::PIN_DS_B_RST] = ~I_DS_B_RESET; // RULE_04
    alt_oe[gafm_pkg::PIN_DS_B_RST] = 1'h1; // RULE_04
    alt_drv[gafm_pkg::PIN_GEN_EVENT] = ~I_GENERAL_EVENT; // RULE_07 RULE_02
    alt_oe[gafm_pkg::PIN_GEN_EVENT] = 1'h1; // RULE_07
  end

  assign gp_oe = I_SW_DIR & ~alt_eff & gafm_pkg::PIN_PRESENT; // RULE_08 RULE_01
  assign pin_out_nxt = ((alt_eff & alt_drv) | (~alt_eff & I_SW_OUT)) & gafm_pkg::PIN_PRESENT;
  assign pin_oe_nxt = (alt_eff & alt_oe) | gp_oe;
  assign gpio_in_nxt = I_PIN_IN & ~alt_eff & gafm_pkg::PIN_PRESENT; // RULE_01

  a_reset_a_drive: assert property ( // RULE_03
    @(posedge I_MCLK) disable iff (!I_RST_N)
    alt_eff[0] |=> O_PIN_OE[0] && (O_PIN_OUT[0] == !$past(I_DS_A_RESET))
  ) else $error("pin 0 alternate reset wrong");

  a_reset_b_drive: assert property ( // RULE_04
    @(posedge I_MCLK) disable iff (!I_RST_N)
    alt_eff[1] |=> O_PIN_OE[1] && (O_PIN_OUT[1] == !$past(I_DS_B_RESET))
  ) else $error("pin 1 alternate reset wrong");

  a_event_drive: assert property ( // RULE_07
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (alt_eff[7] && I_GENERAL_EVENT) |=> O_PIN_OE[7] && !O_PIN_OUT[7]
  ) else $error("general event not driven low");

  a_event_idle: assert property ( // RULE_02
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (alt_eff[7] && !I_GENERAL_EVENT) |=> O_PIN_OE[7] && O_PIN_OUT[7]
  ) else $error("idle general event not driven high");

  a_gp_direction: assert property ( // RULE_08
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (!alt_eff[3] && !alt_eff[5]) |=> (O_PIN_OE[3] == $past(I_SW_DIR[3]))
      && (O_PIN_OE[5] == $past(I_SW_DIR[5]))
  ) else $error("gpio direction not followed");

  a_gp_output: assert property ( // RULE_01
    @(posedge I_MCLK) disable iff (!I_RST_N)
    !alt_eff[11] |=> O_PIN_OUT[11] == $past(I_SW_OUT[11])
  ) else $error("gpio 11 output wrong");

  a_no_alt_effect: assert property ( // RULE_11
    @(posedge I_MCLK) disable iff (!I_RST_N)
    alt_r[3] |=> (O_PIN_OE[3] == $past(I_SW_DIR[3]))
      && (O_PIN_OUT[3] == $past(I_SW_OUT[3]))
  ) else $error("select on pin 3 changed its gpio use");

  a_gpio_input: assert property ( // RULE_01
    @(posedge I_MCLK) disable iff (!I_RST_N)
    !alt_eff[6] |=> O_GPIO_IN[6] == $past(I_PIN_IN[6])
  ) else $error("gpio 6 input wrong");

  a_absent_pins: assert property ( // RULE_01
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (O_PIN_OE[10:8] == 3'h0) && (O_PIN_OUT[10:8] == 3'h0) && (O_GPIO_IN[10:8] == 3'h0)
  ) else $error("unbonded pin shows activity");

  // inputs on pins 2 and 4 are active low
  assign irq0_now = irq_seen(alt_eff[gafm_pkg::PIN_EXP_IRQ0],
                             I_PIN_IN[gafm_pkg::PIN_EXP_IRQ0]); // RULE_05
  assign irq2_now = irq_seen(alt_eff[gafm_pkg::PIN_EXP_IRQ2],
                             I_PIN_IN[gafm_pkg::PIN_EXP_IRQ2]); // RULE_06
  assign irq_any = irq0_now | irq2_now;
  assign irq_edge = irq_any & ~irq_prev_r; // RULE_10

  a_irq0_input: assert property ( // RULE_05
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (alt_eff[2] && !I_PIN_IN[2]) |=> O_EXPANDER_IRQ0 && !O_PIN_OE[2]
  ) else $error("expander irq0 missed");

  a_irq2_input: assert property ( // RULE_06
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (alt_eff[4] && !I_PIN_IN[4]) |=> O_EXPANDER_IRQ2 && !O_PIN_OE[4]
  ) else $error("expander irq2 missed");

  a_irq0_release: assert property ( // RULE_05
    @(posedge I_MCLK) disable iff (!I_RST_N)
    !irq0_now |=> !O_EXPANDER_IRQ0
  ) else $error("expander irq0 held without cause");

  a_irq2_release: assert property ( // RULE_06
    @(posedge I_MCLK) disable iff (!I_RST_N)
    !irq2_now |=> !O_EXPANDER_IRQ2
  ) else $error("expander irq2 held without cause");

  always_comb begin
    hp_nxt = hp_r;
    case (hp_r)
      gafm_pkg::GAFM_HP_IDLE: if (irq_edge) hp_nxt = gafm_pkg::GAFM_HP_REQ; // RULE_10
      gafm_pkg::GAFM_HP_REQ: hp_nxt = gafm_pkg::GAFM_HP_WAIT;
      gafm_pkg::GAFM_HP_WAIT: if (I_HP_READ_DONE) hp_nxt = gafm_pkg::GAFM_HP_IDLE;
      default: hp_nxt = gafm_pkg::GAFM_HP_IDLE;
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      alt_r <= gafm_pkg::RST_ALT;
      O_PIN_OUT <= gafm_pkg::RST_OUT;
      O_PIN_OE <= gafm_pkg::RST_DIR;
      O_GPIO_IN <= gafm_pkg::RST_IN;
      O_ALT_SEL <= gafm_pkg::RST_ALT;
      O_EXPANDER_IRQ0 <= 1'h0;
      O_EXPANDER_IRQ2 <= 1'h0;
      O_HP_READ_REQ <= 1'h0;
      irq_prev_r <= 1'h0;
      hp_r <= gafm_pkg::GAFM_HP_IDLE;
    end else begin
      alt_r <= alt_nxt;
      O_ALT_SEL <= alt_eff;
      O_PIN_OUT <= pin_out_nxt;
      O_PIN_OE <= pin_oe_nxt;
      O_GPIO_IN <= gpio_in_nxt; // RULE_01
      O_EXPANDER_IRQ0 <= irq0_now; // RULE_05
      O_EXPANDER_IRQ2 <= irq2_now; // RULE_06
      O_HP_READ_REQ <= (hp_nxt == gafm_pkg::GAFM_HP_REQ); // RULE_10
      irq_prev_r <= irq_any;
      hp_r <= hp_nxt;
    end
  end

  a_hp_request: assert property ( // RULE_10
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (irq_edge && hp_r == gafm_pkg::GAFM_HP_IDLE) |=> O_HP_READ_REQ ##1 !O_HP_READ_REQ
  ) else $error("hot-plug read not requested");

  a_hp_single: assert property ( // RULE_10
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (hp_r == gafm_pkg::GAFM_HP_WAIT) |=> !O_HP_READ_REQ
  ) else $error("hot-plug read requested while one is open");

  a_hp_done: assert property ( // RULE_10
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (hp_r == gafm_pkg::GAFM_HP_WAIT && I_HP_READ_DONE) |=> hp_r == gafm_pkg::GAFM_HP_IDLE
  ) else $error("hot-plug read end not taken");
endmodule : gafm_mux

// ---- gafm_board_model.sv ----
// gafm_board_model: board pins, downstream devices and hot-plug expander
// assumes: undriven pins rest at a pull-up, one clock shared with the mux
`timescale 1ns/100ps
module gafm_board_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [11:0] i_pin_out,
  input wire logic [11:0] i_pin_oe,
  input wire logic [1:0] i_irq_n,
  input wire logic i_read_req,
  output logic [11:0] o_pin_in,
  output logic o_read_done
);
  logic [1:0] cnt_r;
  logic [11:0] ext_w;
  // expander lines on pins 2 and 4 pull low while asserted
  assign ext_w = {7'h7F, i_irq_n[1], 1'h1, i_irq_n[0], 2'h3};
  assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & ext_w);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) cnt_r <= 2'h0;
    else if (i_read_req) cnt_r <= 2'h3;
    else if (cnt_r != 2'h0) cnt_r <= cnt_r - 2'h1;
  end
  assign o_read_done = (cnt_r == 2'h1);
endmodule : gafm_board_model

// ---- gpio_alternate_function_mux_tb_top.sv ----
// gpio_alternate_function_mux_tb_top: table and hand-written checks of the pin mux
// assumes: gafm_pkg, gafm_mux and gafm_board_model compiled first
`timescale 1ns/100ps
module gpio_alternate_function_mux_tb_top;
  logic clk = 1'h0, rst_n = 1'h0, sw_we = 1'h0, smb_we = 1'h0, ee_we = 1'h0;
  logic ds_a = 1'h0, ds_b = 1'h0, ev = 1'h0, irq0, irq2, req, done;
  logic [11:0] dir = 12'h000, sw_out = 12'h000, sw_alt = 12'h000;
  logic [11:0] smb_alt = 12'h000, ee_alt = 12'h000, pin_in, pin_out, pin_oe, gpio_in, alt_sel;
  logic [1:0] irq_n = 2'h3;
  int mismatches = 0, checked = 0;
  logic [11:0] exp_in;
  // alt, dir, out, {ds_a, ds_b, event}, expected oe, expected driven out
  logic [71:0] rows [4] = '{72'h000_FFF_A5A_000_8FF_85A, 72'hFFF_000_000_000_083_083,
    72'hFFF_FFF_000_007_8EB_000, 72'h097_8FF_8FF_005_8EB_86A};
  initial forever #2 clk = ~clk;
  gafm_mux u_dut (.I_MCLK(clk), .I_RST_N(rst_n), .I_SW_DIR(dir), .I_SW_OUT(sw_out),
    .I_SW_ALT(sw_alt), .I_SW_ALT_WE(sw_we), .I_SMB_ALT(smb_alt), .I_SMB_ALT_WE(smb_we),
    .I_EE_ALT(ee_alt), .I_EE_ALT_WE(ee_we), .I_DS_A_RESET(ds_a), .I_DS_B_RESET(ds_b),
    .I_GENERAL_EVENT(ev), .I_HP_READ_DONE(done), .I_PIN_IN(pin_in), .O_PIN_OUT(pin_out),
    .O_PIN_OE(pin_oe), .O_GPIO_IN(gpio_in), .O_ALT_SEL(alt_sel), .O_EXPANDER_IRQ0(irq0),
    .O_EXPANDER_IRQ2(irq2), .O_HP_READ_REQ(req));
  gafm_board_model u_board (.i_clk(clk), .i_rst_n(rst_n), .i_pin_out(pin_out),
    .i_pin_oe(pin_oe), .i_irq_n(irq_n), .i_read_req(req), .o_pin_in(pin_in),
    .o_read_done(done));
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic pulse(input logic [2:0] we);
    {ee_we, smb_we, sw_we} = we;
    @(negedge clk);
    {ee_we, smb_we, sw_we} = 3'h0;
    repeat (2) @(negedge clk);
  endtask : pulse
  task automatic wait_req;
    int n;
    for (n = 0; n < 20 && req !== 1'h1; n++) @(negedge clk);
    if (req !== 1'h1) begin
      mismatches++;
      $display("[ERR] hot-plug read request expected 1 seen %b", req);
      summarize();
    end
  endtask : wait_req
  initial begin
    repeat (20) @(negedge clk);
    check("reset oe", 12'h000, pin_oe | alt_sel | {11'h000, req});
    check("reset out", 12'h000, pin_out | gpio_in | {10'h000, irq2, irq0});
    $display("reset test done");
    rst_n = 1'h1;
    for (int i = 0; i < 4; i++) begin
      {sw_alt, dir, sw_out} = rows[i][71:36];
      {ds_a, ds_b, ev} = rows[i][26:24];
      pulse(3'h1);
      check("pin oe", rows[i][23:12], pin_oe);
      check("pin out", rows[i][11:0], pin_out & pin_oe);
      check("alt sel", sw_alt & gafm_pkg::ALT_CAPABLE, alt_sel);
      exp_in = (rows[i][11:0] | ~rows[i][23:12]) & ~(sw_alt & gafm_pkg::ALT_CAPABLE);
      check("gpio in", exp_in & gafm_pkg::PIN_PRESENT, gpio_in);
      $display("row %0d done", i);
    end
    {ee_alt, smb_alt, sw_alt} = {12'h001, 12'h002, 12'h080};
    pulse(3'h7);
    check("alt priority", 12'h001, alt_sel);
    pulse(3'h3);
    check("alt slave bus", 12'h002, alt_sel);
    $display("select sources done");
    ee_alt = 12'h014;
    pulse(3'h4);
    irq_n = 2'h2;
    wait_req();
    check("irq0", 12'h001, {11'h000, irq0});
    @(negedge clk);
    check("req pulse", 12'h000, {11'h000, req});
    repeat (6) @(negedge clk);
    irq_n = 2'h3;
    repeat (3) @(negedge clk);
    irq_n = 2'h1;
    wait_req();
    check("irq2", 12'h002, {10'h000, irq2, irq0});
    $display("expander test done");
    rst_n = 1'h0;
    repeat (2) @(negedge clk);
    check("mid reset oe", 12'h000, pin_oe | alt_sel | {11'h000, req});
    check("mid reset out", 12'h000, pin_out | gpio_in | {10'h000, irq2, irq0});
    rst_n = 1'h1;
    sw_alt = 12'h010;
    pulse(3'h1);
    wait_req();
    check("irq2 after reset", 12'h002, {10'h000, irq2, irq0});
    $display("mid reset test done");
    summarize();
  end
endmodule : gpio_alternate_function_mux_tb_top
